//--- shared/pcc_defines.vh
// register map, field positions, reset values and encodings of the compare/capture block
`ifndef PCC_DEFINES_VH
`define PCC_DEFINES_VH
`define PCC_OFF_CTRL     8'h00
`define PCC_OFF_BP_POS   8'h04
`define PCC_OFF_BP_MOD   8'h08
`define PCC_OFF_BUF      8'h0C
`define PCC_OFF_CAP_CTRL 8'h10
`define PCC_OFF_STATUS   8'h14
`define PCC_OFF_IRQ_STAT 8'h18
`define PCC_OFF_IRQ_MASK 8'h1C
`define PCC_OFF_CAP_POS  8'h20
`define PCC_OFF_TARGET   8'h24
`define PCC_OFF_POS      8'h28
`define PCC_OFF_BUF_LVL  8'h2C
// control fields
`define PCC_CTRL_ENABLE  0
`define PCC_CTRL_MODE_LO 1
`define PCC_CTRL_MODE_HI 2
`define PCC_CTRL_BUFFER  3
`define PCC_CTRL_ACT_LO  4
`define PCC_CTRL_ACT_HI  6
`define PCC_CTRL_RESET   32'h0000_0000
// modes
`define PCC_MODE_ABS     2'h0
`define PCC_MODE_REL     2'h1
`define PCC_MODE_MOD     2'h2
`define PCC_MODE_PER     2'h3
// actions
`define PCC_ACT_NONE     3'h0
`define PCC_ACT_LOW      3'h1
`define PCC_ACT_HIGH     3'h2
`define PCC_ACT_TOGGLE   3'h3
`define PCC_ACT_PULSE    3'h4
// capture modes, bit 0 of capture control is the enable strobe
`define PCC_CAP_EN       0
`define PCC_CAP_MODE_LO  1
`define PCC_CAP_MODE_HI  3
`define PCC_CAP_OFF      3'h0
`define PCC_CAP_HIGH     3'h1
`define PCC_CAP_LOW      3'h2
`define PCC_CAP_RISE     3'h3
`define PCC_CAP_FALL     3'h4
`define PCC_CAP_DIN_HIGH 3'h5
`define PCC_CAP_DIN_LOW  3'h6
// status / interrupt bits
`define PCC_ST_BP        0
`define PCC_ST_CAP       1
`define PCC_ST_MODAL     2
`define PCC_ST_OVERLAP   3
`define PCC_ST_ARMED     4
`define PCC_ST_CAP_ARMED 5
`define PCC_ST_DIN       6
`define PCC_IRQ_BITS     4
// pulse width default in clock cycles
`define PCC_PULSE_CYC    16'h0019
`define PCC_BUF_DEPTH    16
`define PCC_BUF_AW       4
`define PCC_AXI_OKAY     2'h0
`define PCC_AXI_SLVERR   2'h2
`endif

//--- hdl/pcc_buf_mem.v
// breakpoint buffer memory: one write port, registered read data
module pcc_buf_mem #(
  parameter DW = 32,
  parameter AW = 4
) (
  // clock
  input  wire          aclk,
  // write port
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  // read port
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

//--- hdl/pcc_top.v
// position compare (breakpoint) and high-speed capture for one encoder axis
//
// Our own choices: the address map and register access over AXI4-Lite.
`include "pcc_defines.vh"

// Overview of operation
// - absolute mode: targets, buffered too, are signed 32-bit positions from zero
// - relative single: target is enable-time position plus loaded value
// - relative buffered: first from enable position, then previous target plus next entry
// - modulus mode works single only, points at loaded value plus multiples of modulus
// - modulus enable with value magnitude not below modulus is refused, modal error
// - modulus enable arms nearest forward and reverse points; re-enable arms next
// - periodic: loaded value first; each hit outside an active pulse flags status, arms next period
// - hit drives output low, high, toggle, pulse or unchanged per action
// - output already at action level is forced opposite at enable
// - hit while pulse still active stops generation and disables breakpoint
// - no breakpoint enable or capture when axis feedback is analog; a breakpoint already enabled keeps running
// - level capture modes capture while active, at once if already active
// - edge capture modes capture only on a real transition
// - capture status holds true until capture is enabled again
// - digital-input modes report live trigger level, no enable needed
module pcc_top #(
  parameter HAS_TOGGLE = 1,
  parameter HAS_PULSE  = 1
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // axis position and feedback kind
  input  wire [31:0] enc_pos,
  input  wire        fb_analog,
  // pins
  input  wire        trig_in,
  output reg         bp_out,
  output reg         irq
);
  localparam S_IDLE = 3'b001;
  localparam S_LOAD = 3'b010;
  localparam S_RUN  = 3'b100;

  // registers
  reg  [31:0] ctrl;
  reg  [31:0] bp_pos;
  reg  [31:0] bp_mod;
  reg  [15:0] pulse_cyc;
  reg  [3:0]  cap_mode_r;
  reg  [`PCC_IRQ_BITS-1:0] irq_stat;
  reg  [`PCC_IRQ_BITS-1:0] irq_mask;
  reg  [31:0] cap_pos;
  reg  [31:0] target;
  reg  [31:0] target_rev;
  reg         rev_armed;
  reg         armed;
  reg  [2:0]  state;
  reg  [31:0] last_pos;
  reg  [15:0] pulse_cnt;
  reg  [`PCC_BUF_AW-1:0] wr_ptr;
  reg  [`PCC_BUF_AW-1:0] rd_ptr;
  reg  [`PCC_BUF_AW:0]   buf_lvl;
  reg         cap_stat;
  reg         cap_armed;
  reg         trig_s1;
  reg         trig_s2;
  reg         trig_d;
  reg         aw_hold;
  reg         w_hold;
  reg  [7:0]  aw_addr;
  reg  [31:0] w_data;

  wire [1:0]  mode   = ctrl[`PCC_CTRL_MODE_HI:`PCC_CTRL_MODE_LO];
  wire [2:0]  action = ctrl[`PCC_CTRL_ACT_HI:`PCC_CTRL_ACT_LO];
  wire        buffered = ctrl[`PCC_CTRL_BUFFER] && (mode == `PCC_MODE_ABS ||
                         mode == `PCC_MODE_REL);
  wire [2:0]  cap_mode = cap_mode_r[2:0];
  wire [31:0] buf_rd;
  wire        buf_empty = (buf_lvl == {(`PCC_BUF_AW+1){1'b0}});

  // write path: address and data taken in either order
  wire        wr_go   = aw_hold && w_hold && !s_axi_bvalid;
  wire        wr_ctrl = wr_go && aw_addr == `PCC_OFF_CTRL;
  wire        en_req  = wr_ctrl && w_data[`PCC_CTRL_ENABLE];
  wire        wr_buf  = wr_go && aw_addr == `PCC_OFF_BUF &&
                        !buf_lvl[`PCC_BUF_AW];
  wire        cap_en  = wr_go && aw_addr == `PCC_OFF_CAP_CTRL &&
                        w_data[`PCC_CAP_EN];

  pcc_buf_mem #(
    .DW (32),
    .AW (`PCC_BUF_AW)
  ) u_buf (
    .aclk    (aclk),
    .wr_en   (wr_buf),
    .wr_addr (wr_ptr),
    .wr_data (w_data),
    .rd_addr (rd_ptr),
    .rd_data (buf_rd)
  );

  // magnitude of breakpoint value against modulus
  wire [31:0] pos_abs = bp_pos[31] ? (~bp_pos + 32'h0000_0001) : bp_pos;
  wire        mod_bad = (pos_abs >= bp_mod) || (bp_mod == 32'h0000_0000);

  // nearest modulus points around the current position
  wire [31:0] mod_diff = enc_pos - bp_pos;
  // remainder kept in its own signed net so the mux cannot make it unsigned
  wire signed [31:0] mod_rem_s = $signed(mod_diff) % $signed(bp_mod);
  wire [31:0] mod_rem  = (bp_mod == 32'h0000_0000) ? 32'h0000_0000 : mod_rem_s;
  wire [31:0] mod_remp = mod_rem[31] ? mod_rem + bp_mod : mod_rem;
  wire [31:0] mod_back = enc_pos - mod_remp;
  wire [31:0] mod_fwd  = mod_back + bp_mod;

  // crossing detection in either direction
  wire        fwd_hit = ($signed(last_pos) < $signed(target)) &&
                        ($signed(enc_pos) >= $signed(target));
  wire        rev_hit = ($signed(last_pos) > $signed(target)) &&
                        ($signed(enc_pos) <= $signed(target));
  wire        at_hit  = (enc_pos == target);
  wire        mr_hit  = rev_armed && (($signed(last_pos) > $signed(target_rev)) &&
                        ($signed(enc_pos) <= $signed(target_rev)));
  wire        hit     = armed && (fwd_hit || rev_hit || at_hit || mr_hit);
  wire        pulse_busy = (pulse_cnt != 16'h0000);
  wire        act_ok  = (action == `PCC_ACT_TOGGLE) ? (HAS_TOGGLE != 0) :
                        (action == `PCC_ACT_PULSE)  ? (HAS_PULSE != 0) : 1'b1;

  // events
  wire        ev_overlap = hit && pulse_busy;
  wire        ev_bp      = hit && !pulse_busy;
  wire        ev_modal   = en_req && w_data[`PCC_CTRL_MODE_HI:`PCC_CTRL_MODE_LO] ==
                           `PCC_MODE_MOD && mod_bad;
  wire        ev_cap_raw = (cap_mode == `PCC_CAP_HIGH && trig_s2) ||
                           (cap_mode == `PCC_CAP_LOW && !trig_s2) ||
                           (cap_mode == `PCC_CAP_RISE && trig_s2 && !trig_d) ||
                           (cap_mode == `PCC_CAP_FALL && !trig_s2 && trig_d);
  wire        ev_cap     = cap_armed && ev_cap_raw && !fb_analog;
  wire [`PCC_IRQ_BITS-1:0] ev_vec = {ev_overlap, ev_modal, ev_cap, ev_bp};

  // axi write handshake, address and data latching, write response
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PCC_AXI_OKAY;
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        aw_hold       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_hold       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr > `PCC_OFF_BUF_LVL || aw_addr[1:0] != 2'h0) ?
                        `PCC_AXI_SLVERR : `PCC_AXI_OKAY;
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read channel: one cycle from address to data
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `PCC_AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `PCC_AXI_OKAY;
      case (s_axi_araddr)
        `PCC_OFF_CTRL:     s_axi_rdata <= ctrl;
        `PCC_OFF_BP_POS:   s_axi_rdata <= bp_pos;
        `PCC_OFF_BP_MOD:   s_axi_rdata <= bp_mod;
        `PCC_OFF_BUF:      s_axi_rdata <= {16'h0000, pulse_cyc};
        `PCC_OFF_CAP_CTRL: s_axi_rdata <= {28'h0000000, cap_mode_r};
        `PCC_OFF_STATUS:   s_axi_rdata <= {25'h0000000, trig_din(cap_mode, trig_s2),
                                           cap_armed, armed, irq_stat[3:2], cap_stat,
                                           irq_stat[0]};
        `PCC_OFF_IRQ_STAT: s_axi_rdata <= {28'h0000000, irq_stat};
        `PCC_OFF_IRQ_MASK: s_axi_rdata <= {28'h0000000, irq_mask};
        `PCC_OFF_CAP_POS:  s_axi_rdata <= cap_pos;
        `PCC_OFF_TARGET:   s_axi_rdata <= target;
        `PCC_OFF_POS:      s_axi_rdata <= enc_pos;
        `PCC_OFF_BUF_LVL:  s_axi_rdata <= {27'h0000000, buf_lvl};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `PCC_AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // digital-input modes: live level in chosen polarity
  function trig_din;
    input [2:0] m;
    input       t;
    begin
      trig_din = (m == `PCC_CAP_DIN_HIGH) ? t :
                 (m == `PCC_CAP_DIN_LOW) ? !t : 1'b0;
    end
  endfunction

  // software registers and sticky interrupts (write one to clear, set wins)
  always @(posedge aclk) begin
    if (!aresetn) begin
      bp_pos     <= 32'h0000_0000;
      bp_mod     <= 32'h0000_0000;
      pulse_cyc  <= `PCC_PULSE_CYC;
      cap_mode_r <= 4'h0;
      irq_stat   <= {`PCC_IRQ_BITS{1'b0}};
      irq_mask   <= {`PCC_IRQ_BITS{1'b0}};
      irq        <= 1'b0;
    end else begin
      if (wr_go && aw_addr == `PCC_OFF_BP_POS) begin
        bp_pos <= w_data;
      end
      if (wr_go && aw_addr == `PCC_OFF_BP_MOD) begin
        bp_mod <= w_data;
      end
      if (wr_go && aw_addr == `PCC_OFF_CAP_CTRL) begin
        cap_mode_r <= {1'b0, w_data[`PCC_CAP_MODE_HI:`PCC_CAP_MODE_LO]};
      end
      if (wr_go && aw_addr == `PCC_OFF_IRQ_MASK) begin
        irq_mask <= w_data[`PCC_IRQ_BITS-1:0];
      end
      if (wr_go && aw_addr == `PCC_OFF_STATUS) begin
        pulse_cyc <= (w_data[15:0] == 16'h0000) ? 16'h0001 : w_data[15:0];
      end
      if (wr_go && aw_addr == `PCC_OFF_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~w_data[`PCC_IRQ_BITS-1:0]) | ev_vec;
      end else begin
        irq_stat <= irq_stat | ev_vec;
      end
      irq <= |((irq_stat | ev_vec) & irq_mask &
             ~((wr_go && aw_addr == `PCC_OFF_IRQ_STAT) ?
               (w_data[`PCC_IRQ_BITS-1:0] & ~ev_vec) : {`PCC_IRQ_BITS{1'b0}}));
    end
  end

  // capture: synchronise trigger, latch status and position
  always @(posedge aclk) begin
    if (!aresetn) begin
      trig_s1   <= 1'b0;
      trig_s2   <= 1'b0;
      trig_d    <= 1'b0;
      cap_stat  <= 1'b0;
      cap_armed <= 1'b0;
      cap_pos   <= 32'h0000_0000;
    end else begin
      trig_s1 <= trig_in;
      trig_s2 <= trig_s1;
      trig_d  <= trig_s2;
      if (cap_en) begin
        cap_stat  <= 1'b0;
        cap_armed <= !fb_analog && w_data[`PCC_CAP_MODE_HI:`PCC_CAP_MODE_LO] != `PCC_CAP_OFF &&
                     w_data[`PCC_CAP_MODE_HI:`PCC_CAP_MODE_LO] < `PCC_CAP_DIN_HIGH;
      end else if (ev_cap) begin
        cap_stat  <= 1'b1;
        cap_armed <= 1'b0;
        cap_pos   <= enc_pos;
      end
    end
  end

  // breakpoint engine
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl       <= `PCC_CTRL_RESET;
      state      <= S_IDLE;
      armed      <= 1'b0;
      rev_armed  <= 1'b0;
      target     <= 32'h0000_0000;
      target_rev <= 32'h0000_0000;
      last_pos   <= 32'h0000_0000;
      pulse_cnt  <= 16'h0000;
      bp_out     <= 1'b0;
      wr_ptr     <= {`PCC_BUF_AW{1'b0}};
      rd_ptr     <= {`PCC_BUF_AW{1'b0}};
      buf_lvl    <= {(`PCC_BUF_AW+1){1'b0}};
    end else begin
      last_pos <= enc_pos;
      if (wr_buf) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      buf_lvl <= buf_lvl + {{`PCC_BUF_AW{1'b0}}, wr_buf} -
                 {{`PCC_BUF_AW{1'b0}}, (state == S_LOAD && !buf_empty && !wr_ctrl)};
      if (pulse_busy) begin
        pulse_cnt <= pulse_cnt - 16'h0001;
        if (pulse_cnt == 16'h0001) begin
          bp_out <= !bp_out;
        end
      end
      if (wr_ctrl) begin
        ctrl  <= {w_data[31:1], w_data[`PCC_CTRL_ENABLE] && !ev_modal && !fb_analog};
        armed <= 1'b0;
        rev_armed <= 1'b0;
        state <= S_IDLE;
        if (en_req && !ev_modal && !fb_analog) begin
          case (w_data[`PCC_CTRL_ACT_HI:`PCC_CTRL_ACT_LO])
            `PCC_ACT_LOW:  bp_out <= 1'b1;
            `PCC_ACT_HIGH: bp_out <= 1'b0;
            `PCC_ACT_PULSE: bp_out <= 1'b0;
            default: bp_out <= bp_out;
          endcase
          case (w_data[`PCC_CTRL_MODE_HI:`PCC_CTRL_MODE_LO])
            `PCC_MODE_REL: target <= enc_pos + bp_pos;
            `PCC_MODE_MOD: begin
              target     <= mod_fwd;
              target_rev <= mod_back;
              rev_armed  <= 1'b1;
            end
            default: target <= bp_pos;
          endcase
          if (w_data[`PCC_CTRL_BUFFER] &&
              w_data[`PCC_CTRL_MODE_HI:`PCC_CTRL_MODE_LO] < `PCC_MODE_MOD) begin
            state <= S_LOAD;
            if (w_data[`PCC_CTRL_MODE_HI:`PCC_CTRL_MODE_LO] == `PCC_MODE_REL) begin
              target <= enc_pos;
            end else begin
              target <= 32'h0000_0000;
            end
          end else begin
            armed <= 1'b1;
            state <= S_RUN;
          end
        end
      end else begin
        case (state)
          S_IDLE: begin
            armed <= 1'b0;
          end
          S_LOAD: begin
            if (!buf_empty) begin
              rd_ptr <= rd_ptr + 1'b1;
              state  <= S_RUN;
            end
          end
          S_RUN: begin
            if (!armed && buffered) begin
              // buffer read data lands one cycle after the pointer moves
              target <= (mode == `PCC_MODE_REL) ? target + buf_rd : buf_rd;
              armed  <= 1'b1;
            end else if (ev_overlap) begin
              armed <= 1'b0;
              rev_armed <= 1'b0;
              ctrl[`PCC_CTRL_ENABLE] <= 1'b0;
              state <= S_IDLE;
            end else if (ev_bp) begin
              if (act_ok) begin
                case (action)
                  `PCC_ACT_LOW:    bp_out <= 1'b0;
                  `PCC_ACT_HIGH:   bp_out <= 1'b1;
                  `PCC_ACT_TOGGLE: bp_out <= !bp_out;
                  `PCC_ACT_PULSE: begin
                    bp_out    <= 1'b1;
                    pulse_cnt <= pulse_cyc;
                  end
                  default: bp_out <= bp_out;
                endcase
              end
              armed     <= 1'b0;
              rev_armed <= 1'b0;
              if (mode == `PCC_MODE_PER) begin
                target <= target + bp_mod;
                armed  <= 1'b1;
              end else if (buffered && !buf_empty) begin
                state <= S_LOAD;
              end else begin
                ctrl[`PCC_CTRL_ENABLE] <= 1'b0;
                state <= S_IDLE;
              end
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end
endmodule

//--- testbench/pcc_sva.sv
// bus handshake and output checks on the compare/capture block ports
module pcc_sva (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // pins
  input wire logic        fb_analog,
  input wire logic        bp_out,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer not held");
  r_delay_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  b_delay_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  aw_busy_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second write taken");
  ar_busy_a: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
    else $error("second read taken");
  resp_code_a: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0 || s_axi_rresp == 2'h2)
    else $error("bad read response");
  reset_quiet_a: assert property ($rose(aresetn) |-> !bp_out && !irq)
    else $error("outputs active after reset");
  analog_hold_a: assert property (fb_analog && $past(fb_analog) |-> $stable(bp_out))
    else $error("breakpoint output moved on analog axis");
endmodule

bind pcc_top pcc_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .fb_analog, .bp_out, .irq);

//--- testbench/pcc_enc_model.sv
// encoder position source and trigger pin of the axis
module pcc_enc_model (
  // clock
  input  wire logic        aclk,
  // stimulus
  input  wire logic [31:0] goal,
  input  wire logic        trig_req,
  // axis side
  output      logic [31:0] enc_pos,
  output      logic        trig_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial enc_pos = 32'h0000_0000;
  initial trig_in = 1'b0;
  // one count a clock; only the overlap scenario outruns the pulse width
  always @(posedge aclk) begin
    if ($signed(enc_pos) < $signed(goal)) enc_pos <= enc_pos + 32'h0000_0001;
    else if (enc_pos != goal) enc_pos <= enc_pos - 32'h0000_0001;
  end
  // pin is asynchronous to the clock
  always @(trig_req) trig_in <= #1.3 trig_req;
endmodule

//--- testbench/tb_position_compare_and_capture.sv
// bench for the position compare and capture block
`include "pcc_defines.vh"
module tb_position_compare_and_capture;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [1:0] m; logic [2:0] a; logic [31:0] p, g, t; logic f, h;} pcc_row_t;
  logic        aclk = 1'b0, aresetn = 1'b0, fb_analog = 1'b0, trig_req = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, goal = 32'h0, s_axi_rdata, enc_pos;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        bp_out, irq, trig_in;
  logic [1:0]  s_axi_bresp, s_axi_rresp, wresp;
  int          bad_count = 0, comparisons = 0;
  // mode, action, loaded value, travel goal, target, level after enable, level after hit
  pcc_row_t rows[6] = '{
    '{`PCC_MODE_ABS, `PCC_ACT_HIGH, 32'h64, 32'h96, 32'h64, 1'b0, 1'b1},
    '{`PCC_MODE_ABS, `PCC_ACT_HIGH, 32'hFFFF_FFD8, 32'hFFFF_FFC4, 32'hFFFF_FFD8, 1'b0, 1'b1},
    '{`PCC_MODE_REL, `PCC_ACT_LOW, 32'h32, 32'h0, 32'hFFFF_FFF6, 1'b1, 1'b0},
    '{`PCC_MODE_ABS, `PCC_ACT_LOW, 32'h14, 32'h1E, 32'h14, 1'b1, 1'b0},
    '{`PCC_MODE_ABS, `PCC_ACT_TOGGLE, 32'h23, 32'h28, 32'h23, 1'b0, 1'b1},
    '{`PCC_MODE_ABS, `PCC_ACT_NONE, 32'h26, 32'h1E, 32'h26, 1'b1, 1'b1}};

  pcc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .enc_pos, .fb_analog, .trig_in, .bp_out, .irq);
  pcc_enc_model u_enc (.aclk, .goal, .trig_req, .enc_pos, .trig_in);

  initial forever #2 aclk = ~aclk;

  task automatic end_of_test;
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n > 3000) begin
      bad_count++;
      end_of_test();
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      tmo(n);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    wresp = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      tmo(n);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d & m, e);
  endtask
  task automatic mv(input logic [31:0] g);
    int n;
    n = 0;
    goal <= g;
    do begin
      @(posedge aclk);
      n++;
      tmo(n);
    end while (enc_pos !== g);
    cyc(6);
  endtask
  function automatic logic [31:0] ctl(input logic [1:0] m, input logic [2:0] a, input logic b);
    ctl = 32'h1 | (m << `PCC_CTRL_MODE_LO) | (b << `PCC_CTRL_BUFFER) | (a << `PCC_CTRL_ACT_LO);
  endfunction

  initial begin
    logic [31:0] d;
    logic [1:0]  rs;
    cyc(4);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({31'h0, bp_out}, 32'h0);
    foreach (rows[i]) begin
      wr(`PCC_OFF_BP_POS, rows[i].p);
      wr(`PCC_OFF_IRQ_STAT, 32'hF);
      wr(`PCC_OFF_CTRL, ctl(rows[i].m, rows[i].a, 1'b0));
      cyc(2);
      chk({31'h0, bp_out}, {31'h0, rows[i].f});
      rchk(`PCC_OFF_TARGET, 32'hFFFF_FFFF, rows[i].t);
      mv(rows[i].g);
      chk({31'h0, bp_out}, {31'h0, rows[i].h});
      rchk(`PCC_OFF_IRQ_STAT, 32'h1, 32'h1);
      chk({31'h0, irq}, 32'h0);
      $display("row %0d done", i);
    end
    // analog axis: enable refused, no forced level
    fb_analog <= 1'b1;
    wr(`PCC_OFF_CTRL, ctl(`PCC_MODE_ABS, `PCC_ACT_HIGH, 1'b0));
    cyc(2);
    chk({31'h0, bp_out}, 32'h1);
    rchk(`PCC_OFF_STATUS, 32'h10, 32'h0);
    fb_analog <= 1'b0;
    wr(`PCC_OFF_BUF, 32'hA);
    wr(`PCC_OFF_BUF, 32'h14);
    wr(`PCC_OFF_CTRL, ctl(`PCC_MODE_REL, `PCC_ACT_TOGGLE, 1'b1));
    cyc(2);
    rchk(`PCC_OFF_TARGET, 32'hFFFF_FFFF, 32'h28);
    mv(32'h2D);
    rchk(`PCC_OFF_TARGET, 32'hFFFF_FFFF, 32'h3C);
    wr(`PCC_OFF_BP_MOD, 32'hA);
    wr(`PCC_OFF_BP_POS, 32'hA);
    wr(`PCC_OFF_CTRL, ctl(`PCC_MODE_MOD, `PCC_ACT_HIGH, 1'b0));
    rchk(`PCC_OFF_IRQ_STAT, 32'h4, 32'h4);
    rchk(`PCC_OFF_STATUS, 32'h10, 32'h0);
    wr(`PCC_OFF_IRQ_STAT, 32'hF);
    wr(`PCC_OFF_BP_MOD, 32'h2);
    wr(`PCC_OFF_BP_POS, 32'h32);
    wr(`PCC_OFF_CTRL, ctl(`PCC_MODE_PER, `PCC_ACT_PULSE, 1'b0));
    mv(32'h50);
    rchk(`PCC_OFF_IRQ_STAT, 32'h9, 32'h9);
    rchk(`PCC_OFF_STATUS, 32'h10, 32'h0);
    $display("compare tests done");
    trig_req <= 1'b1;
    cyc(4);
    wr(`PCC_OFF_CAP_CTRL, {28'h0, `PCC_CAP_HIGH, 1'b1});
    cyc(5);
    rchk(`PCC_OFF_STATUS, 32'h2, 32'h2);
    rchk(`PCC_OFF_CAP_POS, 32'hFFFF_FFFF, 32'h50);
    trig_req <= 1'b0;
    cyc(5);
    rchk(`PCC_OFF_STATUS, 32'h2, 32'h2);
    trig_req <= 1'b1;
    cyc(5);
    wr(`PCC_OFF_CAP_CTRL, {28'h0, `PCC_CAP_RISE, 1'b1});
    cyc(5);
    rchk(`PCC_OFF_STATUS, 32'h2, 32'h0);
    mv(32'h5A);
    trig_req <= 1'b0;
    cyc(5);
    trig_req <= 1'b1;
    cyc(5);
    rchk(`PCC_OFF_STATUS, 32'h2, 32'h2);
    rchk(`PCC_OFF_CAP_POS, 32'hFFFF_FFFF, 32'h5A);
    wr(`PCC_OFF_IRQ_MASK, 32'h2);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    wr(`PCC_OFF_IRQ_STAT, 32'h2);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    wr(`PCC_OFF_CAP_CTRL, {28'h0, `PCC_CAP_LOW, 1'b1});
    cyc(5);
    rchk(`PCC_OFF_STATUS, 32'h2, 32'h0);
    trig_req <= 1'b0;
    cyc(5);
    rchk(`PCC_OFF_STATUS, 32'h2, 32'h2);
    wr(`PCC_OFF_BP_MOD, 32'hA);
    wr(`PCC_OFF_BP_POS, 32'h3);
    wr(`PCC_OFF_CTRL, ctl(`PCC_MODE_MOD, `PCC_ACT_HIGH, 1'b0));
    rchk(`PCC_OFF_TARGET, 32'hFFFF_FFFF, 32'h5D);
    mv(32'h52);
    chk({31'h0, bp_out}, 32'h1);
    wr(`PCC_OFF_CTRL, ctl(`PCC_MODE_MOD, `PCC_ACT_HIGH, 1'b0));
    rchk(`PCC_OFF_TARGET, 32'hFFFF_FFFF, 32'h53);
    wr(`PCC_OFF_CAP_CTRL, {28'h0, `PCC_CAP_DIN_LOW, 1'b0});
    for (int t = 0; t < 2; t++) begin
      trig_req <= t[0];
      cyc(5);
      rchk(`PCC_OFF_STATUS, 32'h40, {25'h0, ~t[0], 6'h0});
    end
    wr(8'h30, 32'h0);
    chk({30'h0, wresp}, {30'h0, `PCC_AXI_SLVERR});
    rd(8'h30, d, rs);
    chk({30'h0, rs}, {30'h0, `PCC_AXI_SLVERR});
    chk(d, 32'h0);
    $display("capture and bus tests done");
    end_of_test();
  end
endmodule
